// ---- src/sdtm_pkg.sv ----
package sdtm_pkg;

   // Bus window and register offsets (byte addresses, word aligned).
   localparam int          WB_AW          = 8;
   localparam logic [7:0]  REG_CFG4_OFF   = 8'hFC;
   localparam logic [7:0]  REG_STAT_OFF   = 8'hF0;

   // Field positions inside the configuration word.
   localparam int          F_PRE_ACT_LSB  = 28;
   localparam int          F_ACT_PRE_LSB  = 24;
   localparam int          F_WBUF_BIT     = 21;
   localparam int          F_RBUF_BIT     = 20;
   localparam int          F_MODE_LSB     = 8;
   localparam int          F_ACT_RW_LSB   = 4;
   localparam int          F_WR_ACT_LSB   = 0;
   localparam int          F_CODE_W       = 4;
   localparam int          F_MODE_W       = 12;

   // Reset value and writable-bit mask; bits 23-22 never store.
   localparam logic [31:0] REG_CFG4_RESET = 32'h0010_0000;
   localparam logic [31:0] REG_CFG4_WMASK = 32'hFF3F_FFFF;

   // Status word field positions.
   localparam int          S_DONE_LSB     = 0;
   localparam int          S_KIND_LSB     = 4;
   localparam int          S_MODE_SET_BIT = 8;

   // Spacing counts in clocks.
   localparam int          GAP_W          = 5;
   localparam logic [4:0]  GAP_MAX        = 5'h10;
   localparam logic [4:0]  GAP_RW_MIN     = 5'h02;
   localparam logic [4:0]  SINCE_SAT      = 5'h1F;

   typedef enum logic [2:0] {
      SDTM_CMD_ACT,
      SDTM_CMD_PRE,
      SDTM_CMD_RDAP,
      SDTM_CMD_WRAP,
      SDTM_CMD_MRS
   } sdtm_cmd_t;

   // A code of zero stands for the longest spacing.
   function automatic logic [4:0] sdtm_gap_clocks(input logic [3:0] code);
      sdtm_gap_clocks = (code == 4'h0) ? GAP_MAX : {1'b0, code};
   endfunction

   // The one-clock activate to read/write code is illegal; it is held
   // to the shortest legal spacing so a bad write cannot break timing.
   function automatic logic [4:0] sdtm_rw_clocks(input logic [3:0] code);
      logic [4:0] g;
      g = sdtm_gap_clocks(code);
      sdtm_rw_clocks = (g < GAP_RW_MIN) ? GAP_RW_MIN : g;
   endfunction

endpackage

// ---- src/sdtm_reg_if.sv ----
`timescale 1ns/10ps
interface sdtm_reg_if;
   import sdtm_pkg::*;
   logic              wr_stb;
   logic [WB_AW-1:0]  addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_sel;
   logic [31:0]       rd_data;

   modport slave (output wr_stb, addr, wr_data, wr_sel, input rd_data);
   modport regs  (input wr_stb, addr, wr_data, wr_sel, output rd_data);
endinterface

// ---- src/sdtm_gap_timer.sv ----
`timescale 1ns/10ps
module sdtm_gap_timer
   import sdtm_pkg::*;
(
   input  wire logic             clk_i,   // System clock.
   input  wire logic             rst_i,   // Synchronous reset.
   input  wire logic             load_i,  // Start a spacing window.
   input  wire logic [GAP_W-1:0] gap_i,   // Spacing in clocks, 1 to 16.
   output logic                  done_o   // Window has run out.
);
   logic [GAP_W-1:0] cnt;

   // Loading one less makes the next command legal exactly gap clocks
   // after the one that started the window.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (load_i) begin
         cnt <= gap_i - 5'h01;
      end else if (cnt != '0) begin
         cnt <= cnt - 5'h01;
      end
   end

   assign done_o = (cnt == '0);
endmodule

// ---- src/sdtm_wb_slave.sv ----
`timescale 1ns/10ps
module sdtm_wb_slave
   import sdtm_pkg::*;
(
   input  wire logic             clk_i,     // System clock.
   input  wire logic             rst_i,     // Synchronous reset.
   input  wire logic             wb_cyc_i,  // Bus cycle.
   input  wire logic             wb_stb_i,  // Strobe.
   input  wire logic             wb_we_i,   // Write enable.
   input  wire logic [WB_AW-1:0] wb_adr_i,  // Byte address.
   input  wire logic [3:0]       wb_sel_i,  // Byte lanes.
   input  wire logic [31:0]      wb_dat_i,  // Write data.
   output logic [31:0]           wb_dat_o,  // Read data.
   output logic                  wb_ack_o,  // Acknowledge.
   sdtm_reg_if.slave             rif        // Register side.
);
   logic req;

   assign req         = wb_cyc_i && wb_stb_i;
   // Writes land on the edge where the master samples ack.
   assign rif.wr_stb  = req && wb_we_i && wb_ack_o;
   assign rif.addr    = wb_adr_i;
   assign rif.wr_data = wb_dat_i;
   assign rif.wr_sel  = wb_sel_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
         wb_dat_o <= (req && !wb_we_i) ? rif.rd_data : 32'h0000_0000;
      end
   end
endmodule

// ---- src/sdtm_top.sv ----
`timescale 1ns/10ps
module sdtm_top
   import sdtm_pkg::*;
(
   input  wire logic             clk_i,          // 200 MHz system clock.
   input  wire logic             rst_i,          // Synchronous reset.
   input  wire logic             wb_cyc_i,       // Wishbone cycle.
   input  wire logic             wb_stb_i,       // Wishbone strobe.
   input  wire logic             wb_we_i,        // Wishbone write enable.
   input  wire logic [WB_AW-1:0] wb_adr_i,       // Wishbone byte address.
   input  wire logic [3:0]       wb_sel_i,       // Wishbone byte lanes.
   input  wire logic [31:0]      wb_dat_i,       // Wishbone write data.
   output logic [31:0]           wb_dat_o,       // Wishbone read data.
   output logic                  wb_ack_o,       // Wishbone acknowledge.
   input  wire logic             cmd_valid_i,    // Command request held.
   input  wire sdtm_cmd_t        cmd_kind_i,     // Requested command.
   output logic                  cmd_done_o,     // Request taken, pulse.
   output logic                  sd_cmd_valid_o, // SDRAM command slot.
   output sdtm_cmd_t             sd_cmd_kind_o,  // Last issued command.
   output logic [F_MODE_W-1:0]   sd_mode_o,      // Mode word on address.
   output logic                  wr_buf_en_o,    // Write buffer strobe.
   output logic                  rd_buf_en_o     // Read buffer strobe.
);
   sdtm_reg_if rif ();

   sdtm_wb_slave u_slave (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .rif      (rif.slave)
   );

   // Configuration register and its fields.
   logic [31:0]         cfg;
   logic [31:0]         lane_mask;
   logic [31:0]         wr_mask;
   logic                cfg_hit;
   logic                stat_hit;
   logic [3:0]          pre_to_act_clocks;
   logic [3:0]          act_to_pre_clocks;
   logic [3:0]          act_to_rdwr_clocks;
   logic [3:0]          wr_to_act_clocks;
   logic                write_buffer_kind;
   logic                read_buffer_kind;
   logic [F_MODE_W-1:0] sdram_mode_word;
   logic [31:0]         stat_word;
   logic                mode_set;

   assign cfg_hit   = (rif.addr == REG_CFG4_OFF);
   assign stat_hit  = (rif.addr == REG_STAT_OFF);
   assign lane_mask = {{8{rif.wr_sel[3]}}, {8{rif.wr_sel[2]}},
                       {8{rif.wr_sel[1]}}, {8{rif.wr_sel[0]}}};
   assign wr_mask   = lane_mask & REG_CFG4_WMASK;

   assign pre_to_act_clocks  = cfg[F_PRE_ACT_LSB +: F_CODE_W];
   assign act_to_pre_clocks  = cfg[F_ACT_PRE_LSB +: F_CODE_W];
   assign act_to_rdwr_clocks = cfg[F_ACT_RW_LSB  +: F_CODE_W];
   assign wr_to_act_clocks   = cfg[F_WR_ACT_LSB  +: F_CODE_W];
   assign write_buffer_kind  = cfg[F_WBUF_BIT];
   assign read_buffer_kind   = cfg[F_RBUF_BIT];
   assign sdram_mode_word    = cfg[F_MODE_LSB +: F_MODE_W];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= REG_CFG4_RESET;
      end else if (rif.wr_stb && cfg_hit) begin
         cfg <= (cfg & ~wr_mask) | (rif.wr_data & wr_mask);
      end
   end

   // Spacing timers, one per documented interval.
   logic pre_act_done;
   logic act_pre_done;
   logic act_rw_done;
   logic wr_act_done;
   logic gate_ok;
   logic take;
   logic take_act;
   logic take_pre;
   logic take_rd;
   logic take_wr;
   logic take_mrs;

   assign take_act = take && (cmd_kind_i == SDTM_CMD_ACT);
   assign take_pre = take && (cmd_kind_i == SDTM_CMD_PRE);
   assign take_rd  = take && (cmd_kind_i == SDTM_CMD_RDAP);
   assign take_wr  = take && (cmd_kind_i == SDTM_CMD_WRAP);
   assign take_mrs = take && (cmd_kind_i == SDTM_CMD_MRS);

   sdtm_gap_timer u_act_pre (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (take_act),
      .gap_i  (sdtm_gap_clocks(act_to_pre_clocks)),
      .done_o (act_pre_done)
   );

   sdtm_gap_timer u_act_rw (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (take_act),
      .gap_i  (sdtm_rw_clocks(act_to_rdwr_clocks)),
      .done_o (act_rw_done)
   );

   sdtm_gap_timer u_wr_act (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (take_wr),
      .gap_i  (sdtm_gap_clocks(wr_to_act_clocks)),
      .done_o (wr_act_done)
   );

   sdtm_gap_timer u_pre_act (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (take_pre),
      .gap_i  (sdtm_gap_clocks(pre_to_act_clocks)),
      .done_o (pre_act_done)
   );

   // A mode set is held off like an activate, so it never lands on a
   // bank that is still closing.
   always_comb begin
      case (cmd_kind_i)
         SDTM_CMD_ACT:  gate_ok = pre_act_done && wr_act_done;
         SDTM_CMD_PRE:  gate_ok = act_pre_done;
         SDTM_CMD_RDAP: gate_ok = act_rw_done;
         SDTM_CMD_WRAP: gate_ok = act_rw_done;
         SDTM_CMD_MRS:  gate_ok = pre_act_done && wr_act_done;
         default:       gate_ok = 1'b0;
      endcase
   end

   // The done pulse blocks a second take of the same held request.
   assign take = cmd_valid_i && !cmd_done_o && gate_ok;

   // Buffer strobes: registered buffers need one more clock edge.
   logic wr_dly;
   logic rd_dly;
   logic next_wr_buf;
   logic next_rd_buf;

   assign next_wr_buf = (take_wr && !write_buffer_kind) || wr_dly;
   assign next_rd_buf = (take_rd && !read_buffer_kind) || rd_dly;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_done_o     <= 1'b0;
         sd_cmd_valid_o <= 1'b0;
         sd_cmd_kind_o  <= SDTM_CMD_ACT;
         sd_mode_o      <= '0;
         mode_set       <= 1'b0;
         wr_dly         <= 1'b0;
         rd_dly         <= 1'b0;
         wr_buf_en_o    <= 1'b0;
         rd_buf_en_o    <= 1'b0;
      end else begin
         cmd_done_o     <= take;
         sd_cmd_valid_o <= take;
         if (take) begin
            sd_cmd_kind_o <= cmd_kind_i;
         end
         if (take_mrs) begin
            sd_mode_o <= sdram_mode_word;
            mode_set  <= 1'b1;
         end
         wr_dly      <= take_wr && write_buffer_kind;
         rd_dly      <= take_rd && read_buffer_kind;
         wr_buf_en_o <= next_wr_buf;
         rd_buf_en_o <= next_rd_buf;
      end
   end

   // Status shows the live timers, the last command and mode state.
   assign stat_word = {23'h000000, mode_set, 1'b0, sd_cmd_kind_o,
                       wr_act_done, pre_act_done, act_rw_done, act_pre_done};
   assign rif.rd_data = cfg_hit  ? cfg :
                        stat_hit ? stat_word : 32'h0000_0000;

   // Checking helpers: clocks since each activate, precharge and write was shown, and the
   // spacing that was in force when it was taken.
   logic [GAP_W-1:0] since_act;
   logic [GAP_W-1:0] since_pre;
   logic [GAP_W-1:0] since_wr;
   logic [GAP_W-1:0] need_ap;
   logic [GAP_W-1:0] need_rw;
   logic [GAP_W-1:0] need_wa;
   logic [GAP_W-1:0] need_pa;

   function automatic logic [GAP_W-1:0] sat_inc(input logic [GAP_W-1:0] v);
      sat_inc = (v == SINCE_SAT) ? v : v + 5'h01;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_act <= SINCE_SAT;
         since_pre <= SINCE_SAT;
         since_wr  <= SINCE_SAT;
         need_ap   <= GAP_MAX;
         need_rw   <= GAP_MAX;
         need_wa   <= GAP_MAX;
         need_pa   <= GAP_MAX;
      end else begin
         since_act <= take_act ? '0 : sat_inc(since_act);
         since_pre <= take_pre ? '0 : sat_inc(since_pre);
         since_wr  <= take_wr  ? '0 : sat_inc(since_wr);
         if (take_act) begin
            need_ap <= sdtm_gap_clocks(act_to_pre_clocks);
            need_rw <= sdtm_rw_clocks(act_to_rdwr_clocks);
         end
         if (take_wr) begin
            need_wa <= sdtm_gap_clocks(wr_to_act_clocks);
         end
         if (take_pre) begin
            need_pa <= sdtm_gap_clocks(pre_to_act_clocks);
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence shown_s(sdtm_cmd_t k);
      sd_cmd_valid_o && (sd_cmd_kind_o == k);
   endsequence

   sequence rdwr_shown_s;
      shown_s(SDTM_CMD_RDAP) or shown_s(SDTM_CMD_WRAP);
   endsequence

   act_pre_gap_a: assert property (
      shown_s(SDTM_CMD_PRE) |-> (since_act >= need_ap))
      else $error("precharge too soon after activate");

   act_rw_gap_a: assert property (
      rdwr_shown_s |-> (since_act >= need_rw) && (need_rw >= GAP_RW_MIN))
      else $error("read or write too soon after activate");

   wr_act_gap_a: assert property (
      shown_s(SDTM_CMD_ACT) |-> (since_wr >= need_wa))
      else $error("activate too soon after write");

   pre_act_gap_a: assert property (
      shown_s(SDTM_CMD_ACT) |-> (since_pre >= need_pa))
      else $error("activate too soon after precharge");

   wbuf_timing_a: assert property (
      shown_s(SDTM_CMD_WRAP) |->
         if ($past(write_buffer_kind)) (!wr_buf_en_o ##1 wr_buf_en_o)
         else (wr_buf_en_o ##1 !wr_buf_en_o))
      else $error("write buffer strobe timing wrong");

   rbuf_timing_a: assert property (
      shown_s(SDTM_CMD_RDAP) |->
         if ($past(read_buffer_kind)) (!rd_buf_en_o ##1 rd_buf_en_o)
         else (rd_buf_en_o ##1 !rd_buf_en_o))
      else $error("read buffer strobe timing wrong");

   mode_load_a: assert property (
      take_mrs |=> shown_s(SDTM_CMD_MRS) ##0
         (sd_mode_o == $past(sdram_mode_word)))
      else $error("mode word not loaded");

   gate_hold_a: assert property (
      (cmd_valid_i && !cmd_done_o && (cmd_kind_i == SDTM_CMD_PRE) &&
       !act_pre_done) |=> !sd_cmd_valid_o)
      else $error("command issued before timers expired");

   resv_zero_a: assert property (
      (wb_ack_o && $past(cfg_hit) && !$past(wb_we_i)) |->
         (wb_dat_o[23:22] == 2'h0))
      else $error("reserved bits read nonzero");

   resv_store_a: assert property (
      cfg[23:22] == 2'h0)
      else $error("reserved bits stored");

   mrs_gate_a: assert property (
      shown_s(SDTM_CMD_MRS) |->
         (since_pre >= need_pa) && (since_wr >= need_wa))
      else $error("mode set too soon");

   done_pulse_a: assert property (
      cmd_done_o |=> !cmd_done_o)
      else $error("done pulse held too long");
endmodule

// ---- tb/sdtm_sdram_model.sv ----
`timescale 1ns/10ps
module sdtm_sdram_model
   import sdtm_pkg::*;
(
   input  wire logic        clk_i,      // System clock.
   input  wire logic        rst_i,      // Synchronous reset.
   input  wire logic        cmd_vld_i,  // Command slot.
   input  wire sdtm_cmd_t   cmd_kind_i, // Command kind.
   input  wire logic [11:0] mode_i,     // Mode word on the address lines.
   input  wire logic        wr_buf_i,   // Write buffer strobe.
   input  wire logic        rd_buf_i,   // Read buffer strobe.
   output logic [11:0]      mode_reg_o, // Loaded mode register.
   output logic [1:0]       wr_lag_o,   // Write strobe lag, 1 when a cycle late.
   output logic [1:0]       rd_lag_o    // Read strobe lag, 1 when a cycle late.
);
   logic wr_wait;
   logic rd_wait;
   wire  wr_cmd = cmd_vld_i && (cmd_kind_i == SDTM_CMD_WRAP);
   wire  rd_cmd = cmd_vld_i && (cmd_kind_i == SDTM_CMD_RDAP);
   wire  mrs    = cmd_vld_i && (cmd_kind_i == SDTM_CMD_MRS);

   // A registered buffer sees its strobe one cycle after the command.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg_o <= 12'h000;
         wr_lag_o   <= 2'h3;
         rd_lag_o   <= 2'h3;
         wr_wait    <= 1'b0;
         rd_wait    <= 1'b0;
      end else begin
         if (mrs)
            mode_reg_o <= mode_i;
         if (wr_cmd) begin
            wr_lag_o <= wr_buf_i ? 2'h0 : 2'h3;
            wr_wait  <= !wr_buf_i;
         end else if (wr_wait) begin
            wr_lag_o <= wr_buf_i ? 2'h1 : 2'h2;
            wr_wait  <= 1'b0;
         end
         if (rd_cmd) begin
            rd_lag_o <= rd_buf_i ? 2'h0 : 2'h3;
            rd_wait  <= !rd_buf_i;
         end else if (rd_wait) begin
            rd_lag_o <= rd_buf_i ? 2'h1 : 2'h2;
            rd_wait  <= 1'b0;
         end
      end
   end
endmodule

// ---- tb/tb_sdram_timing_mode_config.sv ----
`timescale 1ns/10ps
module tb_sdram_timing_mode_config
   import sdtm_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic        cmd_valid = 1'b0;
   sdtm_cmd_t   cmd_kind = SDTM_CMD_ACT;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        cmd_done_o;
   logic        sd_cmd_valid_o;
   sdtm_cmd_t   sd_cmd_kind_o;
   logic [11:0] sd_mode_o;
   logic        wr_buf_en_o;
   logic        rd_buf_en_o;
   logic [11:0] mode_reg;
   logic [1:0]  wr_lag;
   logic [1:0]  rd_lag;
   int          cyc = 0;
   int          fails = 0;
   int          check_count = 0;

   sdtm_top sdtm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind),
      .cmd_done_o(cmd_done_o), .sd_cmd_valid_o(sd_cmd_valid_o),
      .sd_cmd_kind_o(sd_cmd_kind_o), .sd_mode_o(sd_mode_o),
      .wr_buf_en_o(wr_buf_en_o), .rd_buf_en_o(rd_buf_en_o));

   sdtm_sdram_model sdtm_sdram_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cmd_vld_i(sd_cmd_valid_o), .cmd_kind_i(sd_cmd_kind_o),
      .mode_i(sd_mode_o), .wr_buf_i(wr_buf_en_o), .rd_buf_i(rd_buf_en_o),
      .mode_reg_o(mode_reg), .wr_lag_o(wr_lag), .rd_lag_o(rd_lag));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic wrap_up;
      if (fails == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // The whole run needs well under two thousand cycles.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic issue(input sdtm_cmd_t k, output int t);
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd_kind  <= k;
      do @(posedge clk_i); while (cmd_done_o !== 1'b1);
      cmd_valid <= 1'b0;
      t = cyc;
      check({sd_cmd_valid_o, 28'h0, sd_cmd_kind_o}, {1'b1, 28'h0, k});
   endtask

   function automatic logic [31:0] cfg(input logic [3:0] pa, ap, ar, wa,
                                       input logic wb, rb);
      cfg = {pa, ap, 2'b00, wb, rb, 12'h033, ar, wa};
   endfunction

   task automatic reg_case;
      logic [31:0] q;
      wb_xfer(1'b0, REG_CFG4_OFF, 32'h0, q);
      check(q, 32'h0010_0000);
      wb_xfer(1'b0, REG_STAT_OFF, 32'h0, q);
      check(q, 32'h0000_000F);
      wb_xfer(1'b1, REG_CFG4_OFF, 32'hFFFF_FFFF, q);
      wb_xfer(1'b1, 8'h40, 32'h1234_5678, q);
      wb_xfer(1'b0, 8'h40, 32'h0, q);
      check(q, 32'h0);
      wb_xfer(1'b0, REG_CFG4_OFF, 32'h0, q);
      check(q, 32'hFF3F_FFFF);
   endtask

   task automatic gap_case(input logic [31:0] c, input sdtm_cmd_t a, b,
                           input int n);
      int          t0;
      int          t1;
      logic [31:0] q;
      wb_xfer(1'b1, REG_CFG4_OFF, c, q);
      issue(a, t0);
      issue(b, t1);
      check(t1 - t0, n);
   endtask

   // All four spacings at codes 3, 7, F and 0; code zero gives 16 clocks.
   task automatic spacing_case;
      logic [3:0] codes [4] = '{4'h3, 4'h7, 4'hF, 4'h0};
      logic [3:0] c;
      int         n;
      foreach (codes[i]) begin
         c = codes[i];
         n = (c == 4'h0) ? 16 : int'(c);
         gap_case(cfg(3, c, 3, 3, 0, 1), SDTM_CMD_ACT, SDTM_CMD_PRE, n);
         gap_case(cfg(3, 3, c, 3, 0, 1), SDTM_CMD_ACT, SDTM_CMD_RDAP, n);
         gap_case(cfg(3, 3, 3, c, 0, 1), SDTM_CMD_WRAP, SDTM_CMD_ACT, n);
         gap_case(cfg(c, 3, 3, 3, 0, 1), SDTM_CMD_PRE, SDTM_CMD_ACT, n);
      end
   endtask

   task automatic both_timers_case(input logic [3:0] pa);
      int          t0;
      int          t1;
      int          t2;
      int          t_exp;
      logic [31:0] q;
      wb_xfer(1'b1, REG_CFG4_OFF, cfg(pa, 3, 3, 9, 0, 1), q);
      issue(SDTM_CMD_WRAP, t0);
      issue(SDTM_CMD_PRE, t1);
      issue(SDTM_CMD_ACT, t2);
      t_exp = (t0 + 9 > t1 + pa) ? t0 + 9 : t1 + pa;
      check(t2, t_exp);
   endtask

   task automatic buffer_case(input logic k);
      int          t;
      logic [31:0] q;
      wb_xfer(1'b1, REG_CFG4_OFF, cfg(3, 3, 3, 3, k, k), q);
      issue(SDTM_CMD_WRAP, t);
      repeat (2) @(posedge clk_i);
      #1 check(wr_lag, {1'b0, k});
      issue(SDTM_CMD_RDAP, t);
      repeat (2) @(posedge clk_i);
      #1 check(rd_lag, {1'b0, k});
   endtask

   // Opcode zero and sequential wrap in both words.
   task automatic mode_case(input logic [11:0] m);
      int          t;
      logic [31:0] q;
      wb_xfer(1'b1, REG_CFG4_OFF, {8'h33, 4'h0, m, 8'h33}, q);
      issue(SDTM_CMD_MRS, t);
      check(sd_mode_o, m);
      #1 check(mode_reg, m);
      wb_xfer(1'b0, REG_STAT_OFF, 32'h0, q);
      check(q, 32'h0000_014F);
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      reg_case();
      spacing_case();
      both_timers_case(4'h5);
      both_timers_case(4'hC);
      buffer_case(1'b0);
      buffer_case(1'b1);
      mode_case(12'h033);
      mode_case(12'h022);
      wrap_up();
   end
endmodule
